// ### include/wiper_pkg.sv
// Purpose: shared constants for the serial wiper latch loader
// Assumes: 11-bit serial words, 3 channel select bits then 8 wiper code bits
// Notes: every offset, reset value and width used by more than one file lives here
package wiper_pkg;
  // ==========================================================
  // word layout
  localparam int WORD_BITS = 11;
  localparam int CODE_BITS = 8;
  localparam int SEL_BITS = 3;
  localparam int CODE_LSB = 0;
  localparam int SEL_LSB = 8;
  localparam int MAX_CHANNELS = 6;
  // ==========================================================
  // reset and preset values
  localparam logic [7:0] MIDSCALE_CODE = 8'h80;
  localparam logic [10:0] SHIFT_RESET = 11'h000;
  localparam logic SYNC_IDLE_HIGH = 1'b1;
  localparam int SYNC_STAGES = 2;
endpackage : wiper_pkg

// ### hw/level_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is a slowly changing level from another domain
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ns
module level_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  // ==========================================================
  // synchroniser chain
  logic meta_q; // first stage, may go metastable
  // both stages reset to the idle level of the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync

// ### hw/serial_wiper_latch_loader.sv
// Purpose: serial-input control of a multi-channel 256-position wiper latch bank
// Assumes: sclk, cs_n and sdi come from one host and are synchronous to sclk
// Notes: the link side runs on sclk; latches run on clk_sys behind synchronisers
`timescale 1ns/1ns
module serial_wiper_latch_loader #(
  parameter int NUM_CHANNELS = 6 // 6 or 4 channel variant
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic preset_to_midscale_n,
  input wire logic power_down_n,
  output logic sdo_o,
  output logic sdo_oe,
  output logic [wiper_pkg::MAX_CHANNELS-1:0][wiper_pkg::CODE_BITS-1:0] wiper_latch,
  output logic a_open,
  output logic wiper_to_b
);
  // ==========================================================
  // decode of channel select bits, shared by load logic and covers
  function automatic logic [wiper_pkg::MAX_CHANNELS-1:0] channel_decode(
    input logic [wiper_pkg::SEL_BITS-1:0] channel_select_bits,
    input int num_ch
  );
    logic [wiper_pkg::MAX_CHANNELS-1:0] hit;
    hit = '0;
    // codes beyond the fitted channels select nothing
    for (int k = 0; k < wiper_pkg::MAX_CHANNELS; k++) begin
      if (k < num_ch && int'(channel_select_bits) == k) begin
        hit[k] = 1'b1;
      end
    end
    return hit;
  endfunction : channel_decode

  // ==========================================================
  // link domain (sclk)
  logic [wiper_pkg::WORD_BITS-1:0] serial_shift_register_q; // last 11 bits in
  logic sdo_bit_q; // bit leaving the far end of the register
  logic link_clr; // preset clears the output latch even with sclk stopped

  assign link_clr = rst | ~preset_to_midscale_n;
  // the raw pin is used on purpose: with sclk stopped a synchronised clear
  // would never arrive, and the clear must act whatever the clock does

  // shift only while selected; select high freezes the held word
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      serial_shift_register_q <= wiper_pkg::SHIFT_RESET;
    end else if (!cs_n) begin
      serial_shift_register_q <= {serial_shift_register_q[wiper_pkg::WORD_BITS-2:0], sdi};
    end
  end

  // output latch takes the bit entered eleven edges ago
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      sdo_bit_q <= 1'b0;
    end else if (!cs_n) begin
      sdo_bit_q <= serial_shift_register_q[wiper_pkg::WORD_BITS-1];
    end
  end

  // ==========================================================
  // system domain synchronisers
  logic cs_n_s; // select, synchronised
  logic preset_n_s; // preset, synchronised
  logic power_n_s; // shutdown, synchronised
  // select rides on sclk and both pins on no clock at all, so all three
  // pass two flops before any system logic reads them

  level_sync #(.RESET_VAL(wiper_pkg::SYNC_IDLE_HIGH)) u_cs_sync (
    .clk(clk_sys),
    .rst(rst),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );
  level_sync #(.RESET_VAL(wiper_pkg::SYNC_IDLE_HIGH)) u_preset_sync (
    .clk(clk_sys),
    .rst(rst),
    .async_in(preset_to_midscale_n),
    .sync_out(preset_n_s)
  );
  level_sync #(.RESET_VAL(wiper_pkg::SYNC_IDLE_HIGH)) u_power_sync (
    .clk(clk_sys),
    .rst(rst),
    .async_in(power_down_n),
    .sync_out(power_n_s)
  );

  // ==========================================================
  // edge detection on synchronised levels
  logic cs_n_prev_q; // last value of synchronised select
  logic preset_prev_q; // last value of synchronised preset
  logic load_pulse; // select has just risen
  logic preset_rise; // preset has just been released
  logic [wiper_pkg::SEL_BITS-1:0] sel_field; // address part of held word
  logic [wiper_pkg::CODE_BITS-1:0] code_field; // data part of held word
  logic [wiper_pkg::MAX_CHANNELS-1:0] load_hit; // one-hot latch select

  // history flops for both edges
  // reset to the idle level so that leaving reset makes no false edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_n_prev_q <= wiper_pkg::SYNC_IDLE_HIGH;
      preset_prev_q <= wiper_pkg::SYNC_IDLE_HIGH;
    end else begin
      cs_n_prev_q <= cs_n_s;
      preset_prev_q <= preset_n_s;
    end
  end

  assign load_pulse = cs_n_s & ~cs_n_prev_q;
  assign preset_rise = preset_n_s & ~preset_prev_q & cs_n_s;
  // the held word is quiet while select is high, so it is safe to read here
  // without its own synchroniser; a host re-selecting within the sync delay
  // would break this, a limitation the host must respect
  assign sel_field = serial_shift_register_q[wiper_pkg::SEL_LSB +: wiper_pkg::SEL_BITS];
  assign code_field = serial_shift_register_q[wiper_pkg::CODE_LSB +: wiper_pkg::CODE_BITS];
  assign load_hit = channel_decode(sel_field, NUM_CHANNELS);

  // ==========================================================
  // wiper latches, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < wiper_pkg::MAX_CHANNELS; ch++) begin : g_latch
      // power-up midscale; preset beats a load; shutdown is not looked at
      // a load and a preset release in one cycle: preset wins, the load is lost
      // shutdown moves the terminal switches and turns off the output driver, never these codes
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          wiper_latch[ch] <= wiper_pkg::MIDSCALE_CODE;
        end else if (!preset_n_s) begin
          wiper_latch[ch] <= wiper_pkg::MIDSCALE_CODE;
        end else if (preset_rise) begin
          wiper_latch[ch] <= wiper_pkg::MIDSCALE_CODE;
        end else if (load_pulse && load_hit[ch]) begin
          wiper_latch[ch] <= code_field;
        end
      end
    end
  endgenerate

  // ==========================================================
  // shutdown and serial output driver
  // open drain: only ever pulls low, and never in shutdown so no pull-up current
  // power_n_s lags the pin by two system cycles, so the driver may stay on that
  // long after shutdown falls; the pull-up only sees a short extra load
  assign sdo_o = 1'b0;
  assign sdo_oe = ~cs_n & power_n_s & ~sdo_bit_q;
  assign a_open = ~power_n_s;
  assign wiper_to_b = ~power_n_s;

  // ==========================================================
  // checks on the link domain
  shift_in_a: assert property (@(posedge sclk) disable iff (rst)
    !cs_n |=> serial_shift_register_q[0] == $past(sdi))
    else $error("bit not shifted in");
  hold_word_a: assert property (@(posedge sclk) disable iff (rst)
    cs_n |=> $stable(serial_shift_register_q))
    else $error("shift register moved while deselected");
  delay_line_a: assert property (@(posedge sclk) disable iff (link_clr)
    !cs_n ##1 !cs_n ##1 !cs_n |-> sdo_bit_q == $past(serial_shift_register_q[wiper_pkg::WORD_BITS-2], 2))
    else $error("output bit not eleven shifts old");

  // ==========================================================
  // checks on the system domain
  preset_mid_a: assert property (@(posedge clk_sys) disable iff (rst)
    !preset_n_s |=> wiper_latch[0] == wiper_pkg::MIDSCALE_CODE
      && wiper_latch[wiper_pkg::MAX_CHANNELS-1] == wiper_pkg::MIDSCALE_CODE)
    else $error("preset did not force midscale");
  load_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    load_pulse && preset_n_s && !preset_rise && sel_field == 3'h0
      |=> wiper_latch[0] == $past(code_field))
    else $error("addressed latch not loaded");
  others_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    load_pulse && preset_n_s && !preset_rise && sel_field == 3'h0 |=> $stable(wiper_latch[1]))
    else $error("unaddressed latch changed");
  bad_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    load_pulse && preset_n_s && !preset_rise && int'(sel_field) >= NUM_CHANNELS |=> $stable(wiper_latch))
    else $error("unused code loaded a latch");
  power_down_n_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    !power_n_s && !load_pulse && preset_n_s && !preset_rise |=> $stable(wiper_latch))
    else $error("shutdown altered a latch");
  power_down_n_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !power_n_s |-> a_open && wiper_to_b && !sdo_oe)
    else $error("shutdown outputs wrong");
  preset_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
    preset_rise |=> wiper_latch[NUM_CHANNELS-1] == wiper_pkg::MIDSCALE_CODE)
    else $error("preset release did not load midscale");

  preset_all_a: assert property (@(posedge clk_sys) disable iff (rst)
    !preset_n_s |=> wiper_latch == {wiper_pkg::MAX_CHANNELS{wiper_pkg::MIDSCALE_CODE}})
    else $error("preset left a latch off midscale");
  // the clear is asynchronous, so it must show even with the link clock stopped
  sdo_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    !preset_to_midscale_n |-> !sdo_bit_q)
    else $error("preset did not clear the output bit");
  // no select edge and no preset event: every latch keeps its code
  keep_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !load_pulse && preset_n_s && !preset_rise |=> $stable(wiper_latch))
    else $error("latch changed without a load");

  // ==========================================================
  // per-channel load checks, one copy for each fitted channel
  // a decode that swaps two channels trips the copy of either one
  generate
    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_load_chk
      load_each_a: assert property (@(posedge clk_sys) disable iff (rst)
        load_pulse && preset_n_s && !preset_rise && int'(sel_field) == c
          |=> wiper_latch[c] == $past(code_field))
        else $error("fitted channel did not take its code");
    end
  endgenerate

  // ==========================================================
  // covers for the main scenarios
  load_seen_c: cover property (@(posedge clk_sys) disable iff (rst) load_pulse && load_hit != '0);
  preset_seen_c: cover property (@(posedge clk_sys) disable iff (rst) preset_rise);
  power_down_n_seen_c: cover property (@(posedge clk_sys) disable iff (rst) !power_n_s ##1 power_n_s);
  bad_code_c: cover property (@(posedge clk_sys) disable iff (rst) load_pulse && load_hit == '0);
  idle_clock_c: cover property (@(posedge sclk) disable iff (rst) cs_n ##1 !cs_n);
endmodule : serial_wiper_latch_loader

// ### testbench/spi_host_model.sv
// Purpose: host model that drives the three-wire serial link
// Assumes: serial clock idles low; only idle_clocks runs it between frames
// Notes: captures the chained output at every falling edge inside a frame
`timescale 1ns/1ns
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_wire
);
  // ==========================================================
  // state
  logic [21:0] rx_q; // bits seen on the chained output, newest in bit 0
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rx_q = '0;
  end
  // ==========================================================
  // frame: n bits msb first, 15 ns clock, then a long deselect
  // the pause keeps select high for five system cycles, past the three the word needs to load
  task automatic frame(input logic [21:0] bits, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #7 sclk = 1'b1;
      #8 sclk = 1'b0;
      rx_q = {rx_q[20:0], sdo_wire};
    end
    sdi = ~sdi; // released line must not keep its last value
    cs_n = 1'b1;
    #100;
  endtask : frame
  // deselected clocks with toggling data, which the device must ignore
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      sdi = ~sdi;
      #7 sclk = 1'b1;
      #8 sclk = 1'b0;
    end
  endtask : idle_clocks
endmodule : spi_host_model

// ### testbench/tb_serial_wiper_latch_loader.sv
// Purpose: self-checking bench for the serial wiper latch loader
// Assumes: six channel build, host model on the link side
// Notes: expectations come from predict, never from the outputs
`timescale 1ns/1ns
module tb_serial_wiper_latch_loader;
  // ==========================================================
  // signals
  logic clk_sys, rst, preset_to_midscale_n, power_down_n;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe, a_open, wiper_to_b;
  logic [wiper_pkg::MAX_CHANNELS-1:0][wiper_pkg::CODE_BITS-1:0] wiper_latch, exp_latch;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  wire sdo_wire = sdo_oe ? sdo_o : 1'b1; // open drain with pull-up
  // ==========================================================
  // instances
  serial_wiper_latch_loader #(.NUM_CHANNELS(6)) uut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .preset_to_midscale_n(preset_to_midscale_n), .power_down_n(power_down_n),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_latch(wiper_latch), .a_open(a_open), .wiper_to_b(wiper_to_b));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_wire(sdo_wire));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // about 34 frames of some 20 cycles each; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // only codes naming a present channel load; the rest change nothing
  function automatic void predict(input logic [10:0] w);
    if (w[10:8] < 3'h6) exp_latch[w[10:8]] = w[7:0];
  endfunction : predict
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // main sequence
  initial begin
    logic [10:0] w;
    logic [21:0] two;
    void'($urandom(54095));
    rst = 1'b1;
    preset_to_midscale_n = 1'b1;
    power_down_n = 1'b1;
    exp_latch = {wiper_pkg::MAX_CHANNELS{wiper_pkg::MIDSCALE_CODE}};
    settle(10);
    rst = 1'b0;
    settle(3);
    check(48'(wiper_latch), 48'(exp_latch));
    // every address code with extreme codes first, then random words
    for (int i = 0; i < 30; i++) begin
      w = (i < 8) ? {i[2:0], (i[0] ? 8'hFF : 8'h00)} : 11'($urandom());
      host.frame({11'h000, w}, 11);
      predict(w);
      settle(6);
      check(48'(wiper_latch), 48'(exp_latch));
    end
    // deselected clocks must not shift: a short frame keeps six old bits
    w = 11'($urandom());
    host.frame({11'h000, w}, 11);
    predict(w);
    host.idle_clocks(7);
    host.frame(22'h000015, 5);
    predict({w[5:0], 5'h15});
    settle(6);
    check(48'(wiper_latch), 48'(exp_latch));
    // chained frame: second word loads, first word comes out delayed by eleven
    two = {11'($urandom()), 11'($urandom())};
    host.frame(two, 22);
    predict(two[10:0]);
    settle(6);
    check(48'(host.rx_q[10:0]), 48'(two[21:11]));
    check(48'(wiper_latch), 48'(exp_latch));
    // shutdown and back: terminals switch, latches stay
    power_down_n = 1'b0;
    settle(4);
    check(48'({a_open, wiper_to_b}), 48'h3);
    // a frame in shutdown: output stays released, unused code loads nothing
    host.frame({11'h000, 3'h7, 8'($urandom())}, 11);
    settle(1);
    check(48'(host.rx_q[10:0]), 48'h7FF);
    check(48'(wiper_latch), 48'(exp_latch));
    power_down_n = 1'b1;
    settle(4);
    check(48'({a_open, wiper_to_b}), 48'h0);
    check(48'(wiper_latch), 48'(exp_latch));
    // preset low forces midscale, release with select high keeps it
    preset_to_midscale_n = 1'b0;
    exp_latch = {wiper_pkg::MAX_CHANNELS{wiper_pkg::MIDSCALE_CODE}};
    settle(4);
    check(48'(wiper_latch), 48'(exp_latch));
    preset_to_midscale_n = 1'b1;
    settle(4);
    check(48'(wiper_latch), 48'(exp_latch));
    complete_run();
  end
endmodule : tb_serial_wiper_latch_loader
